/* hw/iasf_irq_status.v */
// Purpose: Status flag register and interrupt control with priority and vectors.
// Assumes: Core sequencer pulses ops for one cycle; timers pulse overflow for one cycle.
// Notes: Registers reached over a plain strobe port, read data one cycle later.
//
// Behaviour
// - Status register at 0AH, bits 6-7 zero.
// - Status writes leave sleep and watchdog flags.
// - Bit 0 carry, no borrow, rotate.
// - Bit 1 low nibble carry, no borrow.
// - Bit 2 set on zero result.
// - Bit 3 set on carry-in xor carry-out.
// - Sleep flag: cleared by clear op, set by sleep.
// - Watchdog flag: cleared by ops, set by timeout.
// - Status never saved; only counter pushed.
// - Acceptance clears global enable; requests only pend.
// - Full stack blocks acknowledgement.
// - Falling external pin sets external pending flag.
// - External taken to vector 04H, clears flags.
// - Timer 0 overflow pends, vector 08H.
// - Timer 1 bit 3/6, vector 0CH.
// - Control enable bits 0-3, bit 7 zero.
// - Nesting needs global and own enable.
// - Interrupt exit sets global enable; plain keeps.
// - Requests serviced at next phase two pulse.
// - Priority external, timer 0, timer 1.
// - Pending stays until serviced or cleared.
// - Any pending enabled source wakes device.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`include "iasf_regs.vh"
module iasf_irq_status (
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,
    input wire [2:0] alu_op_in,
    input wire [7:0] alu_a_in,
    input wire [7:0] alu_b_in,
    input wire alu_cin_in,
    input wire [7:0] logic_result_in,
    input wire rot_carry_in,
    input wire sleep_op_in,
    input wire watchdog_clear_op_in,
    input wire watchdog_timeout_in,
    input wire irq_exit_op_in,
    input wire plain_exit_op_in,
    input wire phase_two_in,
    input wire stack_full_in,
    input wire external_irq_pin_in,
    input wire tmr0_overflow_in,
    input wire tmr1_overflow_in,
    output reg irq_ack_out,
    output reg [7:0] irq_vector_out,
    output wire wake_out,
    output reg [7:0] alu_result_out,
    output wire return_out
);
    reg [7:0] arith_flags_reg;
    reg [7:0] irq_control_reg;
    reg [2:0] pin_sync;
    reg pin_level;
    reg [7:0] next_flags;
    reg [7:0] next_irqc;
    reg [8:0] sum;
    reg [4:0] nib;
    reg [7:0] low7;
    reg carry_into_msb;
    reg [2:0] take;
    wire ext_fall;
    wire ack_ok;
    wire phase_edge;
    reg phase_d;
    wire wr_flags;
    wire wr_irqc;

    // Address match, shared by the write and read decoders.
    function hit;
        input [7:0] a;
        input [7:0] target;
        begin
            hit = (a == target);
        end
    endfunction

    // Fixed priority pick among enabled pending sources: external, timer 0, timer 1.
    function [2:0] pick_source;
        input [7:0] irqc;
        input allow;
        begin
            pick_source = `IASF_TAKE_NONE;
            if (allow) begin
                if (irqc[`IASF_BIT_EPEND] & irqc[`IASF_BIT_EIE]) begin
                    pick_source = `IASF_TAKE_EXT;
                end else if (irqc[`IASF_BIT_T0PEND] & irqc[`IASF_BIT_T0IE]) begin
                    pick_source = `IASF_TAKE_TMR0;
                end else if (irqc[`IASF_BIT_T1PEND] & irqc[`IASF_BIT_T1IE]) begin
                    pick_source = `IASF_TAKE_TMR1;
                end
            end
        end
    endfunction

    // Vector address for a taken source; zero when nothing is taken.
    function [7:0] vector_of;
        input [2:0] t;
        begin
            case (t)
                `IASF_TAKE_EXT: vector_of = `IASF_VEC_EXT;
                `IASF_TAKE_TMR0: vector_of = `IASF_VEC_TMR0;
                `IASF_TAKE_TMR1: vector_of = `IASF_VEC_TMR1;
                default: vector_of = `IASF_VEC_NONE;
            endcase
        end
    endfunction

    // Read decode: mapped registers return their value, anything else reads zero.
    function [7:0] read_mux;
        input [7:0] a;
        input [7:0] flags;
        input [7:0] irqc;
        begin
            read_mux = `IASF_RESET_BYTE;
            if (hit(a, `IASF_ARITH_FLAGS_ADDR)) begin
                read_mux = flags;
            end else if (hit(a, `IASF_IRQ_CONTROL_ADDR)) begin
                read_mux = irqc;
            end
        end
    endfunction

    // Acceptance clears the taken source's pending flag and the global enable.
    function [7:0] clear_taken;
        input [7:0] irqc;
        input [2:0] t;
        begin
            clear_taken = irqc;
            clear_taken[`IASF_BIT_GIE] = 1'b0;
            if (t == `IASF_TAKE_EXT) begin
                clear_taken[`IASF_BIT_EPEND] = 1'b0;
            end
            if (t == `IASF_TAKE_TMR0) begin
                clear_taken[`IASF_BIT_T0PEND] = 1'b0;
            end
            if (t == `IASF_TAKE_TMR1) begin
                clear_taken[`IASF_BIT_T1PEND] = 1'b0;
            end
        end
    endfunction

    function is_zero;
        input [7:0] v;
        begin
            is_zero = (v == `IASF_RESET_BYTE);
        end
    endfunction

    // Register write decode.
    assign wr_flags = wr_in & hit(addr_in, `IASF_ARITH_FLAGS_ADDR);
    assign wr_irqc = wr_in & hit(addr_in, `IASF_IRQ_CONTROL_ADDR);

    // Three-stage synchroniser; a change counts when stages two and three agree.
    assign ext_fall = pin_level & ~pin_sync[1] & ~pin_sync[2];
    assign phase_edge = phase_two_in & ~phase_d;
    // Only the program counter is pushed by the sequencer; flags are never stacked.
    assign return_out = irq_exit_op_in | plain_exit_op_in;
    assign ack_ok = phase_edge & ~stack_full_in & irq_control_reg[`IASF_BIT_GIE];
    assign wake_out = |(irq_control_reg[`IASF_BIT_T1PEND:`IASF_BIT_EPEND]
        & irq_control_reg[`IASF_BIT_T1IE:`IASF_BIT_EIE]);

    // Fixed priority selection of the source to take.
    always @* begin
        take = pick_source(irq_control_reg, ack_ok);
    end

    // Arithmetic flag computation.
    always @* begin
        next_flags = arith_flags_reg;
        sum = 9'h000;
        nib = 5'h00;
        low7 = 8'h00;
        carry_into_msb = 1'b0;
        case (alu_op_in)
            `IASF_ALU_ADD, `IASF_ALU_SUB: begin
                if (alu_op_in == `IASF_ALU_ADD) begin
                    sum = {1'b0, alu_a_in} + {1'b0, alu_b_in} + {8'h00, alu_cin_in};
                    nib = {1'b0, alu_a_in[3:0]} + {1'b0, alu_b_in[3:0]} + {4'h0, alu_cin_in};
                    low7 = {1'b0, alu_a_in[6:0]} + {1'b0, alu_b_in[6:0]} + {7'h00, alu_cin_in};
                end else begin
                    // Subtraction as a plus not b plus carry; carry out means no borrow.
                    sum = {1'b0, alu_a_in} + {1'b0, ~alu_b_in} + {8'h00, alu_cin_in};
                    nib = {1'b0, alu_a_in[3:0]} + {1'b0, ~alu_b_in[3:0]} + {4'h0, alu_cin_in};
                    low7 = {1'b0, alu_a_in[6:0]} + {1'b0, ~alu_b_in[6:0]} + {7'h00, alu_cin_in};
                end
                carry_into_msb = low7[7];
                next_flags[`IASF_BIT_WRAP] = sum[8];
                next_flags[`IASF_BIT_HALF] = nib[4];
                next_flags[`IASF_BIT_NULL] = is_zero(sum[7:0]);
                next_flags[`IASF_BIT_SWRAP] = carry_into_msb ^ sum[8];
            end
            `IASF_ALU_LOGIC: begin
                next_flags[`IASF_BIT_NULL] = is_zero(logic_result_in);
            end
            `IASF_ALU_ROT: begin
                next_flags[`IASF_BIT_WRAP] = rot_carry_in;
            end
            default: begin
                next_flags = arith_flags_reg;
            end
        endcase
        if (wr_flags) begin
            next_flags = (wdata_in & `IASF_ARITH_MASK)
                | (arith_flags_reg & ~`IASF_ARITH_MASK);
        end
        if (watchdog_clear_op_in) begin
            next_flags[`IASF_BIT_SLEEP] = 1'b0;
            next_flags[`IASF_BIT_WDOG] = 1'b0;
        end
        if (sleep_op_in) begin
            next_flags[`IASF_BIT_SLEEP] = 1'b1;
            next_flags[`IASF_BIT_WDOG] = 1'b0;
        end
        if (watchdog_timeout_in) begin
            next_flags[`IASF_BIT_WDOG] = 1'b1;
        end
        next_flags[`IASF_BIT_TOP:`IASF_BIT_RSVD] = 2'b00;
    end

    // Interrupt control register update.
    always @* begin
        next_irqc = irq_control_reg;
        if (wr_irqc) begin
            next_irqc = wdata_in & `IASF_IRQC_MASK;
        end
        if (irq_exit_op_in) begin
            next_irqc[`IASF_BIT_GIE] = 1'b1;
        end
        if (take != `IASF_TAKE_NONE) begin
            next_irqc = clear_taken(next_irqc, take);
        end
        // Hardware sets are applied last so a same-cycle clear cannot lose them.
        if (ext_fall) begin
            next_irqc[`IASF_BIT_EPEND] = 1'b1;
        end
        if (tmr0_overflow_in) begin
            next_irqc[`IASF_BIT_T0PEND] = 1'b1;
        end
        if (tmr1_overflow_in) begin
            next_irqc[`IASF_BIT_T1PEND] = 1'b1;
        end
        next_irqc[`IASF_BIT_TOP] = 1'b0;
    end

    // Pin synchroniser; the first stage is read only by the second.
    // The idle level is high so no false edge follows reset.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_sync <= `IASF_SYNC_IDLE;
            pin_level <= 1'b1;
        end else if (ce_in) begin
            pin_sync <= {pin_sync[1:0], external_irq_pin_in};
            if (pin_sync[1] == pin_sync[2]) begin
                pin_level <= pin_sync[2];
            end
        end
    end

    // Previous phase two level, for the service-point edge.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase_d <= 1'b0;
        end else if (ce_in) begin
            phase_d <= phase_two_in;
        end
    end

    // Status register.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            arith_flags_reg <= `IASF_RESET_BYTE;
        end else if (ce_in) begin
            arith_flags_reg <= next_flags;
        end
    end

    // Interrupt control register.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_control_reg <= `IASF_RESET_BYTE;
        end else if (ce_in) begin
            irq_control_reg <= next_irqc;
        end
    end

    // Acknowledge pulse, one cycle after the service point.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_ack_out <= 1'b0;
        end else if (ce_in) begin
            irq_ack_out <= (take != `IASF_TAKE_NONE);
        end
    end

    // Vector that goes with the acknowledge.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_vector_out <= `IASF_VEC_NONE;
        end else if (ce_in) begin
            irq_vector_out <= vector_of(take);
        end
    end

    // Read data stands only in the cycle after the read strobe.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= `IASF_RESET_BYTE;
        end else if (ce_in) begin
            if (rd_in) begin
                rdata_out <= read_mux(addr_in, arith_flags_reg, irq_control_reg);
            end else begin
                rdata_out <= `IASF_RESET_BYTE;
            end
        end
    end

    // Adder result for the core, from the add and subtract paths only.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            alu_result_out <= `IASF_RESET_BYTE;
        end else if (ce_in) begin
            alu_result_out <= sum[7:0];
        end
    end
endmodule

/* include/iasf_regs.vh */
// Purpose: Register map, field positions and codes for the interrupt and status flag block.
// Assumes: Included by bare name from the design file.
// Notes: Definitions only.
`ifndef IASF_REGS_VH
`define IASF_REGS_VH
`define IASF_ADDR_W 8
`define IASF_ARITH_FLAGS_ADDR 8'h0a
`define IASF_IRQ_CONTROL_ADDR 8'h0b
`define IASF_RESET_BYTE 8'h00
`define IASF_BIT_WRAP 0
`define IASF_BIT_HALF 1
`define IASF_BIT_NULL 2
`define IASF_BIT_SWRAP 3
`define IASF_BIT_SLEEP 4
`define IASF_BIT_WDOG 5
`define IASF_BIT_GIE 0
`define IASF_BIT_EIE 1
`define IASF_BIT_T0IE 2
`define IASF_BIT_T1IE 3
`define IASF_BIT_EPEND 4
`define IASF_BIT_T0PEND 5
`define IASF_BIT_T1PEND 6
`define IASF_ARITH_MASK 8'h0f
`define IASF_IRQC_MASK 8'h7f
`define IASF_VEC_EXT 8'h04
`define IASF_VEC_TMR0 8'h08
`define IASF_VEC_TMR1 8'h0c
`define IASF_VEC_NONE 8'h00
`define IASF_ALU_NONE 3'h0
`define IASF_ALU_ADD 3'h1
`define IASF_ALU_SUB 3'h2
`define IASF_ALU_LOGIC 3'h3
`define IASF_ALU_ROT 3'h4
`define IASF_TAKE_NONE 3'h0
`define IASF_TAKE_EXT 3'h1
`define IASF_TAKE_TMR0 3'h2
`define IASF_TAKE_TMR1 3'h4
`define IASF_SYNC_IDLE 3'h7
`define IASF_BIT_TOP 7
`define IASF_BIT_RSVD 6
`endif

/* tb/iasf_core_model.sv */
// Purpose: Sequencer and timer side model.
// Assumes: Timer requests from the bench are one-cycle pulses; the full request is held as a level.
// Notes: Phase two is high one cycle in four.
`timescale 1ns/1ns
module iasf_core_model (
    input wire clk_in,
    input wire rst_in,
    input wire t0_req_in,
    input wire t1_req_in,
    input wire full_req_in,
    output wire phase_two_out,
    output reg tmr0_overflow_out,
    output reg tmr1_overflow_out,
    output reg stack_full_out
);
    reg [1:0] cnt;
    assign phase_two_out = (cnt == 2'h3);
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt <= 2'h0;
            tmr0_overflow_out <= 1'b0;
            tmr1_overflow_out <= 1'b0;
            stack_full_out <= 1'b0;
        end else begin
            cnt <= cnt + 2'h1;
            tmr0_overflow_out <= t0_req_in;
            tmr1_overflow_out <= t1_req_in;
            stack_full_out <= full_req_in;
        end
    end
endmodule

/* tb/iasf_irq_status_sva.sv */
// Purpose: Port checks for the interrupt and status flag block.
// Assumes: ce_in stays high during the run.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ns
module iasf_irq_status_sva (
    input wire clk_in,
    input wire rst_in,
    input wire [7:0] addr_in,
    input wire rd_in,
    input wire [7:0] rdata_out,
    input wire irq_ack_out,
    input wire [7:0] irq_vector_out,
    input wire stack_full_in,
    input wire phase_two_in,
    input wire irq_exit_op_in,
    input wire plain_exit_op_in,
    input wire return_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_vector_legal: assert property (irq_ack_out |-> irq_vector_out inside {8'h04, 8'h08, 8'h0c})
        else $error("vector not legal on ack");
    a_vector_idle: assert property (!irq_ack_out |-> irq_vector_out == 8'h00)
        else $error("vector not zero without ack");
    a_ack_single: assert property (irq_ack_out |=> !irq_ack_out)
        else $error("ack lasted two cycles");
    a_full_blocks: assert property (irq_ack_out |-> !$past(stack_full_in))
        else $error("ack while stack full");
    a_phase_point: assert property (irq_ack_out |-> $past(phase_two_in) && !$past(phase_two_in, 2))
        else $error("ack away from phase two edge");
    a_status_top: assert property ($past(rd_in) && $past(addr_in) == 8'h0a |-> rdata_out[7:6] == 2'h0)
        else $error("status top bits not zero");
    a_irqc_top: assert property ($past(rd_in) && $past(addr_in) == 8'h0b |-> !rdata_out[7])
        else $error("control bit 7 not zero");
    a_read_idle: assert property (!$past(rd_in) || !($past(addr_in) inside {8'h0a, 8'h0b}) |-> rdata_out == 8'h00)
        else $error("read data outside read slot");
    a_return_or: assert property (return_out == (irq_exit_op_in || plain_exit_op_in))
        else $error("return not the or of exits");
endmodule
bind iasf_irq_status iasf_irq_status_sva chk (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .irq_ack_out(irq_ack_out),
    .irq_vector_out(irq_vector_out), .stack_full_in(stack_full_in), .phase_two_in(phase_two_in),
    .irq_exit_op_in(irq_exit_op_in), .plain_exit_op_in(plain_exit_op_in), .return_out(return_out));

/* tb/irq_and_status_flags_bench.sv */
// Purpose: Self-checking bench for the interrupt and status flag block.
// Assumes: 50 MHz clock, reset held 12 cycles.
// Notes: Ops vector holds sleep, clear, timeout, irq exit, plain exit.
`timescale 1ns/1ns
module irq_and_status_flags_bench;
    reg clk_in = 0, rst_in = 1, wr = 0, rd = 0, cin = 0, pin = 1, t0 = 0, t1 = 0, full = 0;
    reg [7:0] addr = 0, wdata = 0, a = 0, b = 0;
    reg [2:0] aop = 0;
    reg [7:0] lres = 8'h01;
    reg rcar = 0;
    wire [7:0] res;
    reg [4:0] ops = 0;
    wire [7:0] rdata, vec;
    wire ack, wake, ph, ov0, ov1, sf;
    integer miscompares = 0, check_count = 0, i;
    always #10 clk_in = ~clk_in;
    iasf_core_model core (.clk_in(clk_in), .rst_in(rst_in), .t0_req_in(t0), .t1_req_in(t1),
        .full_req_in(full), .phase_two_out(ph), .tmr0_overflow_out(ov0),
        .tmr1_overflow_out(ov1), .stack_full_out(sf));
    iasf_irq_status dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .alu_op_in(aop),
        .alu_a_in(a), .alu_b_in(b), .alu_cin_in(cin), .logic_result_in(lres),
        .rot_carry_in(rcar), .sleep_op_in(ops[0]), .watchdog_clear_op_in(ops[1]),
        .watchdog_timeout_in(ops[2]), .irq_exit_op_in(ops[3]), .plain_exit_op_in(ops[4]),
        .phase_two_in(ph), .stack_full_in(sf), .external_irq_pin_in(pin),
        .tmr0_overflow_in(ov0), .tmr1_overflow_in(ov1), .irq_ack_out(ack),
        .irq_vector_out(vec), .wake_out(wake), .alu_result_out(res), .return_out());
    task chk(input [7:0] s, input [7:0] e);
        begin
            check_count = check_count + 1;
            if (s !== e) begin
                miscompares = miscompares + 1;
                $display("Error at %0t: seen %h expected %h", $time, s, e);
            end
        end
    endtask
    task wreg(input [7:0] ad, input [7:0] d);
        begin
            @(posedge clk_in); addr <= ad; wdata <= d; wr <= 1;
            @(posedge clk_in); wr <= 0;
        end
    endtask
    task rreg(input [7:0] ad, input [7:0] e);
        begin
            @(posedge clk_in); addr <= ad; rd <= 1;
            @(posedge clk_in); rd <= 0;
            #1 chk(rdata, e);
        end
    endtask
    task op(input [4:0] v);
        begin
            @(posedge clk_in); ops <= v;
            @(posedge clk_in); ops <= 0;
        end
    endtask
    task alu(input [2:0] k, input [7:0] x, input [7:0] y, input c, input [7:0] r, input [7:0] e);
        begin
            @(posedge clk_in); aop <= k; a <= x; b <= y; cin <= c;
            @(posedge clk_in); aop <= 0;
            #1 chk(res, r);
            rreg(8'h0a, e);
        end
    endtask
    task wack(input [7:0] v);
        begin
            i = 0;
            while (ack !== 1'b1 && i < 40) begin @(posedge clk_in); #1 i = i + 1; end
            chk({7'h0, ack}, 8'h01);
            chk(vec, v);
        end
    endtask
    task t_regs;
        begin
            rreg(8'h0a, 8'h00); rreg(8'h0b, 8'h00); rreg(8'h05, 8'h00);
            wreg(8'h0a, 8'hff); rreg(8'h0a, 8'h0f);
            alu(3'h1, 8'h0f, 8'h01, 1'b0, 8'h10, 8'h02);
            alu(3'h1, 8'h80, 8'h80, 1'b0, 8'h00, 8'h0d);
            alu(3'h2, 8'h10, 8'h01, 1'b1, 8'h0f, 8'h01);
            @(posedge clk_in); lres <= 8'h00;
            alu(3'h3, 8'h00, 8'h00, 1'b0, 8'h00, 8'h05);
            alu(3'h4, 8'h00, 8'h00, 1'b0, 8'h00, 8'h04);
            @(posedge clk_in); rcar <= 1'b1; lres <= 8'h01;
            alu(3'h4, 8'h00, 8'h00, 1'b0, 8'h00, 8'h05);
            alu(3'h3, 8'h00, 8'h00, 1'b0, 8'h00, 8'h01);
        end
    endtask
    task t_power_flags;
        begin
            wreg(8'h0a, 8'h00);
            op(5'h01); rreg(8'h0a, 8'h10);
            op(5'h04); rreg(8'h0a, 8'h30);
            wreg(8'h0a, 8'hff); rreg(8'h0a, 8'h3f);
            op(5'h02); rreg(8'h0a, 8'h0f);
            op(5'h04); op(5'h01); rreg(8'h0a, 8'h1f);
        end
    endtask
    task t_irq;
        begin
            wreg(8'h0b, 8'h06);
            @(posedge clk_in); pin <= 0; t0 <= 1;
            @(posedge clk_in); t0 <= 0;
            repeat (8) @(posedge clk_in);
            #1 chk({7'h0, ack}, 8'h00);
            rreg(8'h0b, 8'h36);
            @(posedge clk_in); pin <= 1;
            wreg(8'h0b, 8'h37); wack(8'h04);
            rreg(8'h0b, 8'h26);
            op(5'h10); rreg(8'h0b, 8'h26);
            op(5'h08); wack(8'h08);
            rreg(8'h0b, 8'h06);
            @(posedge clk_in); full <= 1;
            wreg(8'h0b, 8'h09);
            @(posedge clk_in); t1 <= 1;
            @(posedge clk_in); t1 <= 0;
            repeat (12) begin @(posedge clk_in); #1 chk({7'h0, ack}, 8'h00); end
            chk({7'h0, wake}, 8'h01);
            @(posedge clk_in); full <= 0;
            wack(8'h0c);
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 0;
        t_regs;
        t_power_flags;
        t_irq;
        results;
    end
    initial begin
        #200000;
        miscompares = miscompares + 1;
        results;
    end
endmodule
